// ===== core/lnc_pkg.sv
// Purpose: shared constants of the LIN transceiver control block
// Assumes: 125 MHz ref_clk, APB register access
// Notes:   register offsets are byte addresses of 32-bit words
package lnc_pkg;
  // clock and timing
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned WAKE_DOM_US    = 70;
  localparam int unsigned TX_DOM_TOUT_US = 5000;
  // least times, so rounding up is exact here (integer MHz)
  localparam int unsigned WAKE_DOM_CYC   = WAKE_DOM_US * CLK_MHZ;
  localparam int unsigned TX_DOM_CYC     = TX_DOM_TOUT_US * CLK_MHZ;

  // register map
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_IRQ_STA = 8'h08;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h0c;
  localparam logic [7:0] OFF_IRQ_EN  = 8'h10;

  // control fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_RATE_LSB = 2;
  localparam int unsigned CTRL_WAKE_EN  = 4;
  localparam logic [1:0]  MODE_DISABLE  = 2'h0;
  localparam logic [1:0]  MODE_TXRX     = 2'h1;
  localparam logic [1:0]  MODE_SLEEP    = 2'h2;
  localparam logic [1:0]  RATE_20K      = 2'h0;
  localparam logic [1:0]  RATE_10K      = 2'h1;
  localparam logic [1:0]  RATE_FAST     = 2'h2;
  localparam logic [1:0]  MODE_RST      = MODE_DISABLE;
  localparam logic [1:0]  RATE_RST      = RATE_20K;
  localparam logic        WAKE_EN_RST   = 1'b0;

  // status fields
  localparam int unsigned ST_DOM_FAULT = 0;
  localparam int unsigned ST_UV        = 1;
  localparam int unsigned ST_OT        = 2;
  localparam int unsigned ST_RXD       = 3;
  localparam int unsigned ST_TXD       = 4;
  localparam int unsigned ST_MODE_LSB  = 5;

  // interrupt bits
  localparam int unsigned IRQ_W       = 4;
  localparam int unsigned IRQ_WAKE    = 0;
  localparam int unsigned IRQ_DOM     = 1;
  localparam int unsigned IRQ_UV      = 2;
  localparam int unsigned IRQ_OT      = 3;
  localparam logic [3:0]  IRQ_EN_RST  = 4'h0;

  typedef enum logic [2:0] {
    W_IDLE = 3'b001,
    W_DOM  = 3'b010,
    W_LONG = 3'b100
  } lnc_wake_state_t;
endpackage : lnc_pkg

// ===== core/lnc_dom_timer.sv
// Purpose: continuous-low timer for the transmit input
// Assumes: run drops for at least one cycle between low periods
// Notes:   expired holds until run falls
`timescale 1ns/1ps
`default_nettype none
module lnc_dom_timer
  import lnc_pkg::*;
#(
  parameter int unsigned LIMIT = TX_DOM_CYC
) (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic run,
  output logic      expired
);
  logic [31:0] cnt_q;

  // restart on every release so only one low period counts
  always_ff @(posedge ref_clk) begin
    if (srst || !run) begin
      cnt_q <= 32'h0; // [R14]
    end else if (cnt_q != LIMIT) begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  assign expired = run && (cnt_q == LIMIT);

  a_timer_restart: assert property (@(posedge ref_clk) // [R14]
    disable iff (srst) !run |=> !expired)
    else $error("timer not restarted by release");
endmodule : lnc_dom_timer
`default_nettype wire

// ===== core/lnc_wake_det.sv
// Purpose: bus wake-up detector used while the link sleeps
// Assumes: busLevel high means recessive
// Notes:   dominant must outlast LIMIT cycles before the release counts
`timescale 1ns/1ps
`default_nettype none
module lnc_wake_det
  import lnc_pkg::*;
#(
  parameter int unsigned LIMIT = WAKE_DOM_CYC
) (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic enable,
  input  wire logic busLevel,
  output logic      wakePulse
);
  lnc_wake_state_t state_q;
  logic [31:0]     cnt_q;
  logic            prevBus_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prevBus_q <= 1'b1;
    end else begin
      prevBus_q <= busLevel;
    end
  end

  // falling edge, long dominant, rising edge, strictly in order
  always_ff @(posedge ref_clk) begin
    if (srst || !enable) begin
      state_q   <= W_IDLE; // [R13]
      cnt_q     <= 32'h0;
      wakePulse <= 1'b0;
    end else begin
      wakePulse <= 1'b0;
      unique case (state_q)
        W_IDLE: begin
          // the first dominant sample already counts toward the limit
          if (prevBus_q && !busLevel) begin
            state_q <= W_DOM; // [R11]
            cnt_q   <= 32'h1;
          end else begin
            cnt_q <= 32'h0;
          end
        end
        W_DOM: begin
          if (busLevel) begin
            state_q <= W_IDLE;
          end else if (cnt_q == LIMIT) begin
            state_q <= W_LONG; // [R11]
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        W_LONG: begin
          if (busLevel) begin
            state_q   <= W_IDLE;
            wakePulse <= 1'b1; // [R11]
          end
        end
      endcase
    end
  end

  a_wake_after_long: assert property (@(posedge ref_clk) // [R11]
    disable iff (srst)
    $rose(wakePulse) |-> $past(state_q) == W_LONG && $past(busLevel))
    else $error("wake reported without long dominant");
  a_wake_disabled: assert property (@(posedge ref_clk) // [R13]
    disable iff (srst) !enable |=> !wakePulse)
    else $error("disabled detector reported wake");
endmodule : lnc_wake_det
`default_nettype wire

// ===== core/lnc_lin_ctl.sv
// Purpose: control logic of a single-wire LIN physical interface
// Assumes: all inputs synchronous to ref_clk; APB slave, zero wait
// Notes:   analog slew and pull-ups are steered by the outputs below
//
// How it works
// R1: supply undervoltage forces transmitter recessive
// R2: link active only in chip Normal mode
// R3: software selects 20k, 10k or fast rate
// R4: overtemperature disables transmitter and receiver
// R5: low transmit input drives bus dominant
// R6: long low input forces recessive, flags fault
// R7: receive output mirrors bus level
// R8: transmit-receive command ignored while input low
// R9: sleep disables transmit, keeps bus watched
// R10: sleep swaps strong pull-up for weak one
// R11: wake needs fall, long dominant, rise
// R12: wake notifies, interrupts or restarts regulator
// R13: wake detection enabled by software
// R14: timeout restarts whenever input returns high
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module lnc_lin_ctl
  import lnc_pkg::*;
#(
  parameter int unsigned TX_DOM_LIMIT = TX_DOM_CYC,
  parameter int unsigned WAKE_LIMIT   = WAKE_DOM_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // microcontroller side
  input  wire logic        txd,
  output logic             rxd,
  // bus side
  input  wire logic        linLevel,
  output logic             linDrvOn,
  output logic [1:0]       rateSel,
  output logic             pullupStrong,
  output logic             pullupWeak,
  // chip state and monitors
  input  wire logic        chipNormal,
  input  wire logic        lowPowerRegOn,
  input  wire logic        lowPowerRegOff,
  input  wire logic        linSupplyLow,
  input  wire logic        overTemp,
  output logic             wakeNotify,
  output logic             wakeIrq,
  output logic             regRestart,
  output logic             irq
);
  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [1:0]         mode_q;
  logic [1:0]         rate_q;
  logic               wakeEn_q;
  logic [IRQ_W-1:0]   irqSta_q;
  logic [IRQ_W-1:0]   irqSta_d;
  logic [IRQ_W-1:0]   irqEn_q;
  logic               domFault;
  logic               wakePulse;
  logic               domFault_q;
  logic               uv_q;
  logic               ot_q;
  logic               linActive;
  logic               txEnable;
  logic               rxEnable;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_IRQ_STA)
          || (a == OFF_IRQ_CLR) || (a == OFF_IRQ_EN);
  endfunction : mapped

  logic setup;
  logic access;
  logic wrCtrl;
  logic [1:0] wrMode;
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wrCtrl = access && pwrite && paddr == OFF_CTRL;
  assign wrMode = pwdata[CTRL_MODE_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one access cycle, read data captured in setup
  assign pready  = 1'b1;
  assign pslverr = access && !mapped(paddr);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata <= 32'h0;
    end else if (setup && !pwrite) begin
      unique case (paddr)
        OFF_CTRL: begin
          prdata <= {27'h0, wakeEn_q, rate_q, mode_q};
        end
        OFF_STATUS: begin
          prdata <= {25'h0, mode_q, txd, rxd, ot_q, uv_q, domFault_q};
        end
        OFF_IRQ_STA: begin
          prdata <= {28'h0, irqSta_q};
        end
        OFF_IRQ_EN: begin
          prdata <= {28'h0, irqEn_q};
        end
        default: begin
          prdata <= 32'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register
  // reserved mode code is dropped rather than stored
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mode_q <= MODE_RST;
    end else if (wrCtrl) begin
      if (wrMode == MODE_TXRX) begin
        if (txd) begin
          mode_q <= MODE_TXRX; // [R8]
        end
      end else if (wrMode != 2'h3) begin
        mode_q <= wrMode; // [R9]
      end
    end
  end

  // a refused transmit-receive write still takes rate and wake bits
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rate_q   <= RATE_RST;
      wakeEn_q <= WAKE_EN_RST;
    end else if (wrCtrl) begin
      rate_q   <= pwdata[CTRL_RATE_LSB +: 2]; // [R3]
      wakeEn_q <= pwdata[CTRL_WAKE_EN]; // [R13]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irqEn_q <= IRQ_EN_RST;
    end else if (access && pwrite && paddr == OFF_IRQ_EN) begin
      irqEn_q <= pwdata[IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit and receive paths
  // fast rate gets no special handling here, the slew stage owns it
  assign linActive = chipNormal && mode_q == MODE_TXRX; // [R2]
  assign rxEnable  = linActive && !overTemp; // [R4]
  assign txEnable  = rxEnable && !linSupplyLow && !domFault; // [R1] [R6]

  // timer runs only while the link may drive, so sleep never trips it
  lnc_dom_timer #(
    .LIMIT   (TX_DOM_LIMIT)
  ) u_dom_timer (
    .ref_clk (ref_clk),
    .srst    (srst),
    .run     (linActive && !txd), // [R14]
    .expired (domFault)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      linDrvOn <= 1'b0;
      rxd      <= 1'b1;
    end else begin
      linDrvOn <= txEnable && !txd; // [R5]
      rxd      <= rxEnable ? linLevel : 1'b1; // [R7]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rateSel      <= RATE_RST;
      pullupStrong <= 1'b1;
      pullupWeak   <= 1'b0;
    end else begin
      rateSel      <= rate_q; // [R3]
      pullupStrong <= mode_q != MODE_SLEEP; // [R10]
      pullupWeak   <= mode_q == MODE_SLEEP; // [R10]
    end
  end

  // status copies lag one cycle; edge events are taken against them
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      domFault_q <= 1'b0;
      uv_q       <= 1'b0;
      ot_q       <= 1'b0;
    end else begin
      domFault_q <= domFault; // [R6]
      uv_q       <= linSupplyLow;
      ot_q       <= overTemp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake-up
  lnc_wake_det #(
    .LIMIT     (WAKE_LIMIT)
  ) u_wake_det (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .enable    (wakeEn_q && mode_q == MODE_SLEEP), // [R9] [R13]
    .busLevel  (linLevel),
    .wakePulse (wakePulse)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wakeNotify <= 1'b0;
      wakeIrq    <= 1'b0;
      regRestart <= 1'b0;
    end else begin
      wakeNotify <= wakePulse; // [R12]
      wakeIrq    <= wakePulse && lowPowerRegOn; // [R12]
      regRestart <= wakePulse && lowPowerRegOff; // [R12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over a same-cycle clear
  logic [IRQ_W-1:0] irqEvt;
  logic [IRQ_W-1:0] irqClr;
  always_comb begin
    irqEvt           = '0;
    irqEvt[IRQ_WAKE] = wakePulse;
    irqEvt[IRQ_DOM]  = domFault && !domFault_q;
    irqEvt[IRQ_UV]   = linSupplyLow && !uv_q;
    irqEvt[IRQ_OT]   = overTemp && !ot_q;
    irqClr = '0;
    if (access && pwrite && paddr == OFF_IRQ_CLR) begin
      irqClr = pwdata[IRQ_W-1:0];
    end
    irqSta_d = (irqSta_q & ~irqClr) | irqEvt;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irqSta_q <= '0;
      irq      <= 1'b0;
    end else begin
      irqSta_q <= irqSta_d;
      irq      <= |(irqSta_d & irqEn_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_uv_recessive: assert property (linSupplyLow |=> !linDrvOn) // [R1]
    else $error("driver on during undervoltage");
  a_not_normal_off: assert property (!chipNormal |=> !linDrvOn && rxd) // [R2]
    else $error("link active outside normal mode");
  a_rate_write: assert property (wrCtrl |=> ##1 // [R3]
    rateSel == $past(pwdata[CTRL_RATE_LSB +: 2], 2))
    else $error("rate select not taken");
  a_ot_disables: assert property (overTemp |=> !linDrvOn && rxd) // [R4]
    else $error("link not disabled by overtemperature");
  a_tx_dominant: assert property (txEnable && !txd |=> linDrvOn) // [R5]
    else $error("dominant not driven");
  a_tx_recessive: assert property (txd |=> !linDrvOn) // [R5]
    else $error("driver on with input high");
  sequence s_long_low;
    linActive && !txd && domFault;
  endsequence
  a_dom_timeout: assert property (s_long_low |=> // [R6]
    !linDrvOn && domFault_q)
    else $error("dominant timeout not enforced");
  a_rx_mirror: assert property (rxEnable |=> rxd == $past(linLevel)) // [R7]
    else $error("receive output wrong");
  a_txrx_refused: assert property (wrCtrl && wrMode == MODE_TXRX // [R8]
    && !txd |=> mode_q == $past(mode_q))
    else $error("transmit-receive taken with input low");
  a_sleep_pullup: assert property (mode_q == MODE_SLEEP |=> // [R9] [R10]
    !linDrvOn ##0 pullupWeak && !pullupStrong)
    else $error("sleep state not applied");
  a_wake_irq: assert property (wakePulse && lowPowerRegOn |=> // [R12]
    wakeIrq && wakeNotify ##1 irqSta_q[IRQ_WAKE])
    else $error("wake not reported");

  // recovery, parking and reporting
  sequence s_tx_clear;
    linActive && !overTemp && !linSupplyLow && !domFault && !txd;
  endsequence
  a_tx_resume: assert property ($fell(linSupplyLow | overTemp) // [R1] [R4]
    ##0 s_tx_clear |=> linDrvOn)
    else $error("transmitter not resumed");
  // receiver parks recessive so the host never sees a stale dominant
  a_rx_released: assert property (!rxEnable |=> rxd) // [R4] [R7]
    else $error("receive output not parked high");
  a_pullup_awake: assert property (mode_q != MODE_SLEEP |=> // [R10]
    pullupStrong && !pullupWeak)
    else $error("strong pull-up missing outside sleep");
  a_mode_legal: assert property (mode_q != 2'h3) // [R8] [R9]
    else $error("reserved mode code stored");
  a_txrx_entry: assert property (mode_q == MODE_TXRX // [R8]
    && $past(mode_q) != MODE_TXRX |-> $past(txd))
    else $error("transmit-receive entered with input low");
  a_ctrl_hold: assert property (!wrCtrl |=> // [R3] [R13]
    rate_q == $past(rate_q) && wakeEn_q == $past(wakeEn_q))
    else $error("control field changed without a write");
  a_wake_gated: assert property (!wakeEn_q || mode_q != MODE_SLEEP // [R13]
    |=> !wakePulse)
    else $error("wake reported while detector off");

  sequence s_wake_off;
    wakePulse && lowPowerRegOff;
  endsequence
  sequence s_restart_out;
    regRestart && wakeNotify;
  endsequence
  a_wake_restart: assert property (s_wake_off |=> s_restart_out) // [R12]
    else $error("regulator restart not requested");
  a_wake_quiet: assert property (!wakePulse |=> // [R12]
    !wakeNotify && !wakeIrq && !regRestart)
    else $error("wake report without detector pulse");
  // set wins: an event in the cycle of its own clear still sticks
  a_sticky_set: assert property (|irqEvt |=> // [R6] [R12]
    (irqSta_q & $past(irqEvt)) == $past(irqEvt))
    else $error("interrupt event lost");
  a_irq_level: assert property (1'b1 |=> // [R12]
    irq == |(irqSta_q & $past(irqEn_q)))
    else $error("interrupt level wrong");
endmodule : lnc_lin_ctl
`default_nettype wire

// ===== testbench/lnc_bus_model.sv
// Purpose: LIN bus with its other nodes, as seen from the link block
// Assumes: nodeDom is commanded by the bench, one cycle resolution
// Notes:   wired-AND bus, held recessive high by the pull-ups
`timescale 1ns/1ps
`default_nettype none
module lnc_bus_model (
  input  wire logic linDrvOn,
  input  wire logic nodeDom,
  output logic      linLevel
);
  // any node pulling low wins; a pull-up always holds it high otherwise
  assign linLevel = !(linDrvOn || nodeDom);
endmodule : lnc_bus_model
`default_nettype wire

// ===== testbench/tb_lin_transceiver_control.sv
// Purpose: self-checking bench of the LIN link control block
// Assumes: shortened counts, 20 cycles timeout and 10 cycles wake
// Notes:   bus nodes modelled by lnc_bus_model
`timescale 1ns/1ps
`default_nettype none
module tb_lin_transceiver_control;
  import lnc_pkg::*;
  localparam int unsigned TDOM  = 20;
  localparam int unsigned TWAKE = 10;
  logic        ref_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        txd, rxd, linLevel, linDrvOn, nodeDom, lastErr;
  logic [1:0]  rateSel;
  logic        pullupStrong, pullupWeak, chipNormal, linSupplyLow;
  logic        lowPowerRegOn, lowPowerRegOff, overTemp;
  logic        wakeNotify, wakeIrq, regRestart, irq;
  int          numErrors, checks;

  lnc_lin_ctl #(.TX_DOM_LIMIT(TDOM), .WAKE_LIMIT(TWAKE)) DUT (
    .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .txd(txd), .rxd(rxd),
    .linLevel(linLevel), .linDrvOn(linDrvOn), .rateSel(rateSel),
    .pullupStrong(pullupStrong), .pullupWeak(pullupWeak),
    .chipNormal(chipNormal), .lowPowerRegOn(lowPowerRegOn),
    .lowPowerRegOff(lowPowerRegOff), .linSupplyLow(linSupplyLow),
    .overTemp(overTemp), .wakeNotify(wakeNotify), .wakeIrq(wakeIrq),
    .regRestart(regRestart), .irq(irq));
  lnc_bus_model bus (.linDrvOn(linDrvOn), .nodeDom(nodeDom),
    .linLevel(linLevel));

  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, numErrors);
    if (numErrors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      numErrors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  // request held until pready is sampled high, released at that edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      numErrors++;
      finish_test();
    end
    rd = prdata;
    lastErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // bus held dominant by another node for len cycles, then released
  task automatic wake_chk(input int len, input int ew, input int ei,
                          input int er);
    int nw, ni, nr;
    nw = 0;
    ni = 0;
    nr = 0;
    @(posedge ref_clk);
    nodeDom <= 1'b1;
    repeat (len) @(posedge ref_clk);
    nodeDom <= 1'b0;
    repeat (8) begin
      tick(1);
      nw += (wakeNotify === 1'b1);
      ni += (wakeIrq === 1'b1);
      nr += (regRestart === 1'b1);
    end
    check("wakeNotify", nw, ew);
    check("wakeIrq", ni, ei);
    check("regRestart", nr, er);
  endtask : wake_chk

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    tick(1);
    check("linDrvOn", linDrvOn, 1'b0);
    check("rxd", rxd, 1'b1);
    check("pullups", {pullupStrong, pullupWeak}, 2'b10);
    check("irq", irq, 1'b0);
    apb(1'b0, OFF_CTRL, 32'h0);
    check("ctrlRst", rd, 32'h0);
    check("mapErr", lastErr, 1'b0);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapErr", lastErr, 1'b1);
    check("unmapRd", rd, 32'h0);
  endtask : t_reset

  task automatic t_modecmd;
    @(posedge ref_clk);
    txd <= 1'b0;
    apb(1'b1, OFF_CTRL, {28'h0, RATE_10K, MODE_TXRX});
    apb(1'b0, OFF_CTRL, 32'h0);
    check("ctrlTxdLow", rd[3:0], {RATE_10K, MODE_DISABLE});
    @(posedge ref_clk);
    txd <= 1'b1;
    apb(1'b1, OFF_CTRL, {28'h0, RATE_20K, MODE_TXRX});
    apb(1'b1, OFF_CTRL, {28'h0, RATE_20K, 2'h3});
    apb(1'b0, OFF_CTRL, 32'h0);
    check("ctrlTxdHigh", rd[3:0], {RATE_20K, MODE_TXRX});
  endtask : t_modecmd

  task automatic t_rates;
    logic [1:0] r [3] = '{RATE_20K, RATE_10K, RATE_FAST};
    foreach (r[i]) begin
      apb(1'b1, OFF_CTRL, {28'h0, r[i], MODE_TXRX});
      tick(1);
      check("rateSel", rateSel, r[i]);
    end
  endtask : t_rates

  // each pass gates the driver by undervoltage, overtemp, non-normal
  task automatic t_txrx;
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      txd <= 1'b0;
      tick(2);
      check("drvOn", linDrvOn, 1'b1);
      check("rxdDom", rxd, 1'b0);
      @(posedge ref_clk);
      nodeDom      <= 1'b1;
      linSupplyLow <= (i == 0);
      overTemp     <= (i == 1);
      chipNormal   <= (i != 2);
      tick(2);
      check("drvGated", linDrvOn, 1'b0);
      check("rxdGated", rxd, i != 0);
      apb(1'b0, OFF_STATUS, 32'h0);
      check("stUv", rd[ST_UV], i == 0);
      check("stOt", rd[ST_OT], i == 1);
      @(posedge ref_clk);
      nodeDom      <= 1'b0;
      linSupplyLow <= 1'b0;
      overTemp     <= 1'b0;
      chipNormal   <= 1'b1;
      tick(2);
      check("drvBack", linDrvOn, 1'b1);
      @(posedge ref_clk);
      txd <= 1'b1;
      tick(2);
      check("drvOff", linDrvOn, 1'b0);
      check("rxdRec", rxd, 1'b1);
    end
    apb(1'b0, OFF_IRQ_STA, 32'h0);
    check("staUv", rd[IRQ_UV], 1'b1);
    check("staOt", rd[IRQ_OT], 1'b1);
  endtask : t_txrx

  task automatic t_timeout;
    apb(1'b1, OFF_IRQ_CLR, 32'hf);
    apb(1'b1, OFF_IRQ_EN, 32'h1 << IRQ_DOM);
    @(posedge ref_clk);
    txd <= 1'b0;
    repeat (TDOM - 5) @(posedge ref_clk);
    txd <= 1'b1;
    repeat (2) @(posedge ref_clk);
    txd <= 1'b0;
    tick(TDOM - 5);
    check("noTimeout", linDrvOn, 1'b1);
    tick(10);
    check("timeout", linDrvOn, 1'b0);
    check("irqDom", irq, 1'b1);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("faultSet", rd[ST_DOM_FAULT], 1'b1);
    check("stTxd", rd[ST_TXD], 1'b0);
    check("stRxd", rd[ST_RXD], 1'b1);
    check("stMode", rd[ST_MODE_LSB +: 2], MODE_TXRX);
    apb(1'b0, OFF_IRQ_STA, 32'h0);
    check("staDom", rd[3:0], 4'h1 << IRQ_DOM);
    @(posedge ref_clk);
    txd <= 1'b1;
    apb(1'b1, OFF_IRQ_CLR, 32'h1 << IRQ_DOM);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("faultGone", rd[ST_DOM_FAULT], 1'b0);
    tick(2);
    check("irqClr", irq, 1'b0);
    apb(1'b1, OFF_IRQ_EN, 32'h0);
  endtask : t_timeout

  task automatic t_sleep;
    apb(1'b1, OFF_CTRL, {27'h0, 1'b1, RATE_20K, MODE_SLEEP});
    @(posedge ref_clk);
    txd <= 1'b0;
    tick(2);
    check("sleepDrv", linDrvOn, 1'b0);
    check("pullSleep", {pullupStrong, pullupWeak}, 2'b01);
    @(posedge ref_clk);
    txd           <= 1'b1;
    chipNormal    <= 1'b0;
    lowPowerRegOn <= 1'b1;
    wake_chk(TWAKE + 5, 1, 1, 0);
    wake_chk(TWAKE, 0, 0, 0);
    wake_chk(TWAKE + 1, 1, 1, 0);
    @(posedge ref_clk);
    lowPowerRegOn  <= 1'b0;
    lowPowerRegOff <= 1'b1;
    wake_chk(TWAKE + 5, 1, 0, 1);
    apb(1'b0, OFF_IRQ_STA, 32'h0);
    check("staWake", rd[IRQ_WAKE], 1'b1);
    check("irqMasked", irq, 1'b0);
    apb(1'b1, OFF_IRQ_EN, 32'h1 << IRQ_WAKE);
    tick(2);
    check("irqWake", irq, 1'b1);
    apb(1'b1, OFF_IRQ_CLR, 32'h1 << IRQ_WAKE);
    tick(2);
    check("irqWakeClr", irq, 1'b0);
    apb(1'b1, OFF_CTRL, {28'h0, RATE_20K, MODE_SLEEP});
    wake_chk(TWAKE + 5, 0, 0, 0);
    @(posedge ref_clk);
    chipNormal     <= 1'b1;
    lowPowerRegOff <= 1'b0;
    apb(1'b1, OFF_CTRL, {28'h0, RATE_20K, MODE_TXRX});
    tick(2);
    check("pullAwake", {pullupStrong, pullupWeak}, 2'b10);
  endtask : t_sleep

  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    numErrors      = 0;
    checks         = 0;
    srst           = 1'b1;
    psel           = 1'b0;
    penable        = 1'b0;
    pwrite         = 1'b0;
    paddr          = 8'h0;
    pwdata         = 32'h0;
    txd            = 1'b1;
    nodeDom        = 1'b0;
    chipNormal     = 1'b1;
    lowPowerRegOn  = 1'b0;
    lowPowerRegOff = 1'b0;
    linSupplyLow   = 1'b0;
    overTemp       = 1'b0;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset();
    t_modecmd();
    t_rates();
    t_txrx();
    t_timeout();
    t_sleep();
    finish_test();
  end
endmodule : tb_lin_transceiver_control
`default_nettype wire
